// *** common/cbm_cfg.svh ***
// timing, register map and reset constants of the buck mode and soft-start controller
`ifndef CBM_CFG_SVH
`define CBM_CFG_SVH

`define CBM_CLK_NS          20
`define CBM_MIN_OFF_NS      300
`define CBM_MIN_OFF_CYC     ((`CBM_MIN_OFF_NS + `CBM_CLK_NS - 1) / `CBM_CLK_NS)
`define CBM_NA_US           30
`define CBM_NA_CYC          ((`CBM_NA_US * 1000) / `CBM_CLK_NS)
`define CBM_SS_STEP_US      750
`define CBM_SS_STEP_CYC     ((`CBM_SS_STEP_US * 1000) / `CBM_CLK_NS)
`define CBM_SS_TOTAL_MS     3
`define CBM_SS_TOTAL_CYC    ((`CBM_SS_TOTAL_MS * 1000000) / `CBM_CLK_NS)
`define CBM_SS_STEPS        4

`define CBM_OFS_CTRL        12'h000
`define CBM_OFS_STATUS      12'h004
`define CBM_OFS_CYCLES      12'h008
`define CBM_CTRL_RESET      32'h0000_0001
`define CBM_CTRL_EN_BIT     0
`define CBM_ST_UVF_BIT      0
`define CBM_ST_UVPEN_BIT    1
`define CBM_ST_ILIM_LSB     2
`define CBM_ST_MODE_LSB     5
`define CBM_ST_VSEL_LSB     7
`define CBM_ST_STBY_BIT     9

`endif

// *** common/cbm_pkg.sv ***
// types shared by the buck mode and soft-start controller
package cbm_pkg;

	typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} cbm_lvl_e;
	typedef enum logic [1:0] {MODE_SKIP, MODE_NOAUD, MODE_FPWM} cbm_mode_e;
	typedef enum logic [1:0] {VSEL_HIGH, VSEL_LOW, VSEL_ADJ} cbm_vsel_e;

	typedef struct packed {
		logic fb_below_ref;
		logic zero_cross;
		logic valley_over_limit;
		logic neg_limit_trip;
		logic ton_done;
		logic supply_ok;
		logic pg_low_ok;
		logic out_below_uv;
	} cbm_cmp_s;

	typedef struct packed {
		logic       hs_on;
		logic       ls_on;
		logic       ton_start;
		logic       discharge_en;
		logic       uvp_enable;
		logic       uv_fault;
		logic [2:0] ilim_quarters;
	} cbm_drv_s;

endpackage

// *** design/cbm_mode_decode.sv ***
// decodes the multilevel pin states into output voltage and light-load mode
`timescale 1ns/100ps
module cbm_mode_decode (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// decoded pin levels
	input  wire cbm_pkg::cbm_lvl_e output_mode_pin,
	input  wire cbm_pkg::cbm_lvl_e memory_type_select_pin,
	// selection
	output cbm_pkg::cbm_vsel_e     vsel,
	output cbm_pkg::cbm_mode_e     mode
);
	import cbm_pkg::*;

	cbm_vsel_e vsel_reg;
	cbm_mode_e mode_reg;
	cbm_vsel_e vsel_next;
	cbm_mode_e mode_next;

	always_comb begin
		if (output_mode_pin == LVL_HIGH) begin
			vsel_next = (memory_type_select_pin == LVL_HIGH) ? VSEL_HIGH : VSEL_LOW;
			mode_next = MODE_SKIP;
		end else begin
			vsel_next = VSEL_ADJ;
			case (memory_type_select_pin)
				LVL_HIGH: mode_next = MODE_FPWM;
				LVL_MID:  mode_next = MODE_NOAUD;
				default:  mode_next = MODE_SKIP;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vsel_reg <= VSEL_ADJ;
			mode_reg <= MODE_SKIP;
		end else begin
			vsel_reg <= vsel_next;
			mode_reg <= mode_next;
		end
	end

	assign vsel = vsel_reg;
	assign mode = mode_reg;

	a_fixed_skip: assert property (@(posedge pclk) disable iff (!presetn)
		vsel_reg != VSEL_ADJ |-> mode_reg == MODE_SKIP)
		else $error("fixed output not in pulse-skip");
endmodule

// *** design/cbm_ctrl.sv ***
// constant on-time buck switch control, mode handling and soft-start sequencer
`timescale 1ns/100ps
`include "cbm_cfg.svh"
module cbm_ctrl #(
	parameter int unsigned SS_STEP_CYC  = `CBM_SS_STEP_CYC,
	parameter int unsigned SS_TOTAL_CYC = `CBM_SS_TOTAL_CYC
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// analog flags and pins
	input  wire cbm_pkg::cbm_cmp_s cmp,
	input  wire cbm_pkg::cbm_lvl_e output_mode_pin,
	input  wire cbm_pkg::cbm_lvl_e memory_type_select_pin,
	input  wire logic              deep_sleep_control_input,
	// switch commands and status
	output cbm_pkg::cbm_drv_s      drv,
	output cbm_pkg::cbm_vsel_e     vsel
);
	import cbm_pkg::*;

	typedef enum logic [2:0] {SQ_STANDBY, SQ_SOFT, SQ_RUN, SQ_SOFTEND, SQ_LATCH} cbm_seq_e;
	typedef enum logic [2:0] {SW_IDLE, SW_DEAD_HS, SW_HS, SW_DEAD_LS, SW_LS, SW_NA_LS} cbm_sw_e;

	localparam logic [7:0]  MIN_OFF = 8'(`CBM_MIN_OFF_CYC);
	localparam logic [10:0] NA_CYC  = 11'(`CBM_NA_CYC);
	localparam logic [1:0]  LAST_STEP = 2'(`CBM_SS_STEPS - 1);

	cbm_mode_e   mode;
	cbm_seq_e    seq_reg;
	cbm_seq_e    seq_next;
	cbm_sw_e     sw_reg;
	cbm_sw_e     sw_next;
	logic [7:0]  off_cnt_reg;
	logic [10:0] na_cnt_reg;
	logic [17:0] ss_cnt_reg;
	logic [17:0] step_tmr_reg;
	logic [1:0]  step_reg;
	logic        uv_fault_reg;
	logic        sleep_q_reg;
	logic        sleep_vld_reg;
	logic [31:0] ctrl_reg;
	logic [15:0] cycles_reg;
	logic [31:0] prdata_reg;
	logic        sleep_toggle;
	logic        run_en;
	logic        off_ok;
	logic        na_due;
	logic        ss_end;
	logic        apb_wr;
	logic        apb_setup;

	cbm_mode_decode u_decode (
		.pclk                   (pclk),
		.presetn                (presetn),
		.output_mode_pin        (output_mode_pin),
		.memory_type_select_pin (memory_type_select_pin),
		.vsel                   (vsel),
		.mode                   (mode)
	);

	// firing condition for a new on-time
	function automatic logic fire_ok(input cbm_cmp_s c, input logic off_done);
		fire_ok = c.fb_below_ref && !c.valley_over_limit && off_done;
	endfunction

	// register address decode
	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == `CBM_OFS_CTRL) || (a == `CBM_OFS_STATUS) || (a == `CBM_OFS_CYCLES);
	endfunction

	assign sleep_toggle = sleep_vld_reg && (deep_sleep_control_input != sleep_q_reg);
	assign run_en = ((seq_reg == SQ_SOFT) || (seq_reg == SQ_RUN)) && ctrl_reg[`CBM_CTRL_EN_BIT];
	assign off_ok = off_cnt_reg >= MIN_OFF;
	assign na_due = (mode == MODE_NOAUD) && (na_cnt_reg >= NA_CYC);
	assign ss_end = ss_cnt_reg == 18'(SS_TOTAL_CYC - 1);

	// sequencer
	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			SQ_STANDBY: begin
				if (cmp.supply_ok) begin
					seq_next = SQ_SOFT;
				end
			end
			SQ_SOFT: begin
				if (!cmp.supply_ok) begin
					seq_next = SQ_STANDBY;
				end else if (ss_end) begin
					seq_next = cmp.pg_low_ok ? SQ_RUN : SQ_SOFTEND;
				end
			end
			SQ_RUN: begin
				if (!cmp.supply_ok) begin
					seq_next = SQ_STANDBY;
				end else if (cmp.out_below_uv) begin
					seq_next = SQ_SOFTEND;
				end
			end
			SQ_SOFTEND: seq_next = SQ_LATCH;
			SQ_LATCH: begin
				if (sleep_toggle) begin
					seq_next = SQ_STANDBY;
				end
			end
			default: seq_next = SQ_STANDBY;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_reg <= SQ_STANDBY;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// fault latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_fault_reg <= 1'b0;
		end else if (seq_next == SQ_SOFTEND) begin
			uv_fault_reg <= 1'b1;
		end else if (seq_reg == SQ_LATCH && sleep_toggle) begin
			uv_fault_reg <= 1'b0;
		end
	end

	// deep sleep input edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_q_reg   <= 1'b0;
			sleep_vld_reg <= 1'b0;
		end else begin
			sleep_q_reg   <= deep_sleep_control_input;
			sleep_vld_reg <= 1'b1;
		end
	end

	// soft-start timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_cnt_reg   <= 18'h0;
			step_tmr_reg <= 18'h0;
			step_reg     <= 2'h0;
		end else if (seq_reg != SQ_SOFT) begin
			ss_cnt_reg   <= 18'h0;
			step_tmr_reg <= 18'h0;
			step_reg     <= 2'h0;
		end else begin
			ss_cnt_reg <= ss_cnt_reg + 18'h1;
			if (step_tmr_reg == 18'(SS_STEP_CYC - 1)) begin
				step_tmr_reg <= 18'h0;
				if (step_reg != LAST_STEP) begin
					step_reg <= step_reg + 2'h1;
				end
			end else begin
				step_tmr_reg <= step_tmr_reg + 18'h1;
			end
		end
	end

	// switch state machine
	always_comb begin
		sw_next = sw_reg;
		case (sw_reg)
			SW_IDLE: begin
				if (fire_ok(cmp, off_ok)) begin
					sw_next = SW_DEAD_HS;
				end else if (na_due) begin
					sw_next = SW_NA_LS;
				end
			end
			SW_DEAD_HS: sw_next = SW_HS;
			SW_HS: begin
				if (cmp.ton_done) begin
					sw_next = SW_DEAD_LS;
				end
			end
			SW_DEAD_LS: sw_next = SW_LS;
			SW_LS: begin
				if (fire_ok(cmp, off_ok)) begin
					sw_next = SW_DEAD_HS;
				end else if (mode == MODE_FPWM && cmp.neg_limit_trip) begin
					sw_next = SW_IDLE;
				end else if (mode != MODE_FPWM && cmp.zero_cross) begin
					sw_next = SW_IDLE;
				end
			end
			SW_NA_LS: begin
				if (fire_ok(cmp, off_ok)) begin
					sw_next = SW_DEAD_HS;
				end
			end
			default: sw_next = SW_IDLE;
		endcase
		if (!run_en) begin
			sw_next = SW_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_reg <= SW_IDLE;
		end else begin
			sw_reg <= sw_next;
		end
	end

	// off-time and no-audible counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			off_cnt_reg <= 8'h0;
		end else if (sw_reg == SW_HS) begin
			off_cnt_reg <= 8'h0;
		end else if (!off_ok) begin
			off_cnt_reg <= off_cnt_reg + 8'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			na_cnt_reg <= 11'h0;
		end else if (sw_reg == SW_HS || mode != MODE_NOAUD) begin
			na_cnt_reg <= 11'h0;
		end else if (!na_due) begin
			na_cnt_reg <= na_cnt_reg + 11'h1;
		end
	end

	// outputs
	assign drv.hs_on         = (sw_reg == SW_HS);
	assign drv.ls_on         = (sw_reg == SW_LS) || (sw_reg == SW_NA_LS);
	assign drv.ton_start     = (sw_reg == SW_DEAD_HS);
	assign drv.discharge_en  = (seq_reg == SQ_STANDBY);
	assign drv.uvp_enable    = (seq_reg == SQ_RUN);
	assign drv.uv_fault      = uv_fault_reg;
	assign drv.ilim_quarters = (seq_reg == SQ_SOFT) ? {1'b0, step_reg} + 3'h1 : 3'h4;

	// apb registers
	assign apb_wr    = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !addr_hit(paddr);
	assign prdata    = prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CBM_CTRL_RESET;
		end else if (apb_wr && paddr == `CBM_OFS_CTRL) begin
			ctrl_reg <= {31'h0, pwdata[`CBM_CTRL_EN_BIT]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycles_reg <= 16'h0;
		end else if (apb_wr && paddr == `CBM_OFS_CYCLES) begin
			cycles_reg <= 16'h0;
		end else if (drv.ton_start) begin
			cycles_reg <= cycles_reg + 16'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0;
		end else if (apb_setup && !pwrite) begin
			case (paddr)
				`CBM_OFS_CTRL:   prdata_reg <= ctrl_reg;
				`CBM_OFS_STATUS: begin
					prdata_reg <= 32'h0;
					prdata_reg[`CBM_ST_UVF_BIT]   <= uv_fault_reg;
					prdata_reg[`CBM_ST_UVPEN_BIT] <= drv.uvp_enable;
					prdata_reg[`CBM_ST_ILIM_LSB +: 3] <= drv.ilim_quarters;
					prdata_reg[`CBM_ST_MODE_LSB +: 2] <= mode;
					prdata_reg[`CBM_ST_VSEL_LSB +: 2] <= vsel;
					prdata_reg[`CBM_ST_STBY_BIT]  <= drv.discharge_en;
				end
				`CBM_OFS_CYCLES: prdata_reg <= {16'h0, cycles_reg};
				default:         prdata_reg <= 32'h0;
			endcase
		end
	end

	// checks
	a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
		!(drv.hs_on && drv.ls_on))
		else $error("both switches on");
	a_dead_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(drv.hs_on) |-> !drv.ls_on ##1 1'b1)
		else $error("no dead cycle after high side");
	a_fire_cond: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(drv.hs_on) |-> $past(cmp.fb_below_ref && !cmp.valley_over_limit && off_ok, 2))
		else $error("on-time started without firing condition");
	a_valley_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(sw_reg == SW_IDLE && cmp.valley_over_limit) |=> sw_reg != SW_DEAD_HS)
		else $error("pulse fired over valley limit");
	a_skip_zc: assert property (@(posedge pclk) disable iff (!presetn)
		(sw_reg == SW_LS && mode != MODE_FPWM && cmp.zero_cross) |=> !drv.ls_on)
		else $error("low side kept on past zero crossing");
	a_neg_limit: assert property (@(posedge pclk) disable iff (!presetn)
		(sw_reg == SW_LS && mode == MODE_FPWM && cmp.neg_limit_trip) |=> !drv.ls_on)
		else $error("negative limit ignored");
	a_na_then_hs: assert property (@(posedge pclk) disable iff (!presetn)
		(sw_reg == SW_NA_LS && run_en && fire_ok(cmp, off_ok)) |=> !drv.ls_on ##1 drv.hs_on)
		else $error("forced cycle did not fire on-time");
	a_na_only: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sw_reg == SW_NA_LS) |-> $past(mode == MODE_NOAUD && na_cnt_reg >= NA_CYC))
		else $error("forced cycle outside no-audible timeout");
	a_standby: assert property (@(posedge pclk) disable iff (!presetn)
		seq_reg == SQ_STANDBY |-> !drv.hs_on && !drv.ls_on && drv.discharge_en)
		else $error("switching during standby");
	a_ss_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(seq_reg == SQ_SOFT) |-> drv.ilim_quarters == 3'h1 && !drv.uvp_enable)
		else $error("soft-start not at quarter limit");
	a_ss_end: assert property (@(posedge pclk) disable iff (!presetn)
		(seq_reg == SQ_SOFT && ss_end && cmp.supply_ok) |=>
			(drv.uvp_enable || (uv_fault_reg && seq_reg == SQ_SOFTEND)))
		else $error("soft-start end mishandled");
	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(seq_reg == SQ_LATCH && !sleep_toggle) |=> seq_reg == SQ_LATCH && uv_fault_reg)
		else $error("fault latch released without toggle");
endmodule

// *** sim/cbm_bridge_model.sv ***
// half-bridge, one-shot and comparator model answering the switch commands
`timescale 1ns/100ps
module cbm_bridge_model (
	// clock
	input  wire logic              pclk,
	// switch commands and on-time length
	input  wire cbm_pkg::cbm_drv_s drv,
	input  wire logic [3:0]        ton_len,
	// comparator flags
	output logic                   ton_done,
	output logic                   zero_cross,
	output logic                   neg_limit_trip
);
	import cbm_pkg::*;
	logic [3:0] hs_cnt;
	logic [3:0] ls_cnt;
	always_ff @(posedge pclk) begin
		hs_cnt <= drv.hs_on ? hs_cnt + 4'h1 : 4'h0;
		ls_cnt <= drv.ls_on ? ls_cnt + 4'h1 : 4'h0;
	end
	// one-shot expires after ton_len high-side cycles
	assign ton_done = drv.hs_on && hs_cnt >= ton_len;
	// inductor current reverses after six low-side cycles
	assign zero_cross = drv.ls_on && ls_cnt >= 4'h6;
	// reverse current reaches the negative limit four cycles later
	assign neg_limit_trip = drv.ls_on && ls_cnt >= 4'ha;
endmodule

// *** sim/tb_top.sv ***
// self-checking bench of the buck mode and soft-start controller
`timescale 1ns/100ps
module tb_top;
	import cbm_pkg::*;
	localparam int HS = 8;
	localparam int LS = 7;
	localparam int DIS = 5;
	localparam int UVF = 3;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, err;
	logic        fb = 1'b0, valley = 1'b0, sup = 1'b0, pg = 1'b0, uvl = 1'b0;
	logic        sleep_in = 1'b0, ton_done, zc, nlt, fire_prev, hs_p, ls_p;
	logic [3:0]  ton_len = 4'h3;
	cbm_lvl_e    omp = LVL_LOW, msp = LVL_LOW;
	cbm_cmp_s    cmp;
	cbm_drv_s    drv;
	cbm_vsel_e   vsel;
	int          n_mismatch = 0, check_count = 0, ton_seen = 0, off_cnt, n, base;

	always #10 pclk = ~pclk;
	assign cmp = {fb, zc, valley, nlt, ton_done, sup, pg, uvl};

	cbm_ctrl #(.SS_STEP_CYC(10), .SS_TOTAL_CYC(40)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp(cmp), .output_mode_pin(omp),
		.memory_type_select_pin(msp), .deep_sleep_control_input(sleep_in),
		.drv(drv), .vsel(vsel));
	cbm_bridge_model bridge (.pclk(pclk), .drv(drv), .ton_len(ton_len),
		.ton_done(ton_done), .zero_cross(zc), .neg_limit_trip(nlt));

	function automatic cbm_vsel_e exp_vsel(cbm_lvl_e o, cbm_lvl_e m);
		if (o != LVL_HIGH) return VSEL_ADJ;
		return (m == LVL_HIGH) ? VSEL_HIGH : VSEL_LOW;
	endfunction
	function automatic cbm_mode_e exp_mode(cbm_lvl_e o, cbm_lvl_e m);
		if (o == LVL_HIGH || m == LVL_LOW) return MODE_SKIP;
		return (m == LVL_HIGH) ? MODE_FPWM : MODE_NOAUD;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic wait_drv(input int b, input logic v, input int lim);
		n = 0;
		while (drv[b] !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		tick(6);
		presetn <= 1'b1;
		tick(1);
	endtask

	// watches every cycle for overlap, changeover and firing conditions
	always @(posedge pclk) begin
		if (presetn !== 1'b1) off_cnt = 100;
		else begin
			if (drv.hs_on === 1'b1 && (drv.ls_on === 1'b1 || ls_p === 1'b1)) chk(1, 0);
			if (drv.ls_on === 1'b1 && hs_p === 1'b1) chk(1, 0);
			if (drv.ton_start === 1'b1) begin
				chk(fire_prev, 1);
				chk(off_cnt >= 15, 1);
				ton_seen++;
			end
			off_cnt = (drv.hs_on === 1'b1) ? 0 : off_cnt + 1;
		end
		fire_prev = fb & ~valley;
		hs_p = drv.hs_on;
		ls_p = drv.ls_on;
	end

	initial begin
		#(20 * 20000);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'ha795));
		do_reset();
		chk(drv.discharge_en, 1);
		chk(drv.uvp_enable, 0);
		chk(drv.ilim_quarters, 4);
		apb(0, 12'h000, 0);
		chk(q, 32'h1);
		apb(0, 12'h00c, 0);
		chk(err, 1);
		chk(q, 0);
		apb(0, 12'h004, 0);
		chk(q[9], 1);
		$display("test reset done");
		for (int i = 0; i < 9; i++) begin
			omp <= cbm_lvl_e'(i / 3);
			msp <= cbm_lvl_e'(i % 3);
			tick(3);
			apb(0, 12'h004, 0);
			chk(vsel, exp_vsel(omp, msp));
			chk(q[6:5], exp_mode(omp, msp));
		end
		$display("test modes done");
		omp <= LVL_LOW;
		msp <= LVL_LOW;
		pg <= 1'b1;
		sup <= 1'b1;
		wait_drv(DIS, 0, 50);
		for (int s = 0; s < 4; s++) begin
			tick(s == 0 ? 5 : 10);
			chk(drv.ilim_quarters, s + 1);
			chk(drv.uvp_enable, 0);
		end
		tick(15);
		chk(drv.uvp_enable, 1);
		chk(drv.uv_fault, 0);
		$display("test soft start done");
		repeat (800) begin
			@(posedge pclk);
			fb <= ($urandom % 4) == 0;
			valley <= ($urandom % 5) == 0;
			ton_len <= 4'($urandom % 8 + 1);
		end
		fb <= 1'b0;
		valley <= 1'b0;
		tick(40);
		apb(0, 12'h008, 0);
		chk(q[15:0], ton_seen[15:0]);
		chk(ton_seen > 20, 1);
		apb(1, 12'h008, 0);
		apb(0, 12'h008, 0);
		chk(q, 0);
		base = ton_seen;
		valley <= 1'b1;
		fb <= 1'b1;
		tick(30);
		chk(ton_seen, base);
		apb(1, 12'h000, 0);
		valley <= 1'b0;
		tick(30);
		chk(ton_seen, base);
		apb(1, 12'h000, 1);
		tick(30);
		chk(ton_seen > base, 1);
		fb <= 1'b0;
		msp <= LVL_MID;
		$display("test switching done");
		tick(20);
		wait_drv(LS, 1, 1700);
		chk(n >= 1400 && n < 1500, 1);
		tick(5);
		chk(drv.ls_on, 1);
		fb <= 1'b1;
		wait_drv(HS, 1, 20);
		chk(drv.hs_on, 1);
		fb <= 1'b0;
		wait_drv(LS, 1, 20);
		chk(drv.ls_on, 1);
		tick(40);
		chk({drv.hs_on, drv.ls_on}, 0);
		$display("test no audible done");
		msp <= LVL_HIGH;
		fb <= 1'b1;
		wait_drv(HS, 1, 40);
		fb <= 1'b0;
		wait_drv(LS, 1, 20);
		tick(8);
		chk(drv.ls_on, 1);
		wait_drv(LS, 0, 20);
		chk(n, 3);
		$display("test forced pwm done");
		uvl <= 1'b1;
		wait_drv(UVF, 1, 10);
		chk(drv.uv_fault, 1);
		uvl <= 1'b0;
		tick(20);
		chk(drv.uv_fault, 1);
		chk(drv.hs_on, 0);
		sleep_in <= 1'b1;
		wait_drv(UVF, 0, 10);
		chk(drv.uv_fault, 0);
		pg <= 1'b0;
		wait_drv(DIS, 0, 20);
		tick(50);
		chk(drv.uv_fault, 1);
		chk(drv.uvp_enable, 0);
		sup <= 1'b0;
		do_reset();
		chk(drv.uv_fault, 0);
		chk(drv.discharge_en, 1);
		chk(drv.ilim_quarters, 4);
		$display("test fault done");
		print_verdict();
	end
endmodule
